// ==== design/ushbr_pkg.sv ====
package ushbr_pkg;
  // register byte offsets on the peripheral bus
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_RX_HOLD  = 8'h08;
  localparam logic [7:0] OFS_TX_HOLD  = 8'h0C;
  localparam logic [7:0] OFS_BAUD     = 8'h10;
  localparam logic [7:0] OFS_RX_TOUT  = 8'h14;
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;

  // control register command bits, write one to act
  localparam int CTL_TX_ENABLE   = 4;
  localparam int CTL_TX_DISABLE  = 5;
  localparam int CTL_STATUS_RST  = 8;
  localparam int CTL_ITER_RST    = 10;
  localparam int CTL_START_TOUT  = 11;
  localparam int CTL_NONACK_RST  = 14;

  // channel status bit positions
  localparam int ST_RX_READY     = 0;
  localparam int ST_TX_READY     = 1;
  localparam int ST_BREAK        = 2;
  localparam int ST_RX_DMA_DONE  = 3;
  localparam int ST_TX_DMA_DONE  = 4;
  localparam int ST_OVERRUN      = 5;
  localparam int ST_FRAME        = 6;
  localparam int ST_PARITY       = 7;
  localparam int ST_TIMEOUT      = 8;
  localparam int ST_TX_IDLE      = 9;
  localparam int ST_ITERATION    = 10;
  localparam int ST_TX_BUF_EMPTY = 11;
  localparam int ST_RX_BUF_FULL  = 12;
  localparam int ST_NONACK       = 13;
  localparam int ST_CHANGE_LSB   = 16;
  localparam int ST_LEVEL_LSB    = 20;

  // modem inputs: ring, data set ready, carrier, clear to send
  localparam int MODEM_W         = 4;

  // holding and baud register fields
  localparam int CHAR_W          = 9;
  localparam int SYNC_BIT        = 15;
  localparam int CLKDIV_LSB      = 0;
  localparam int CLKDIV_W        = 16;
  localparam int FRAC_LSB        = 16;
  localparam int FRAC_W          = 3;
  localparam int TOUT_W          = 16;

  // reset values
  localparam logic [CLKDIV_W-1:0] CLKDIV_RST = 16'h0000;
  localparam logic [FRAC_W-1:0]   FRAC_RST   = 3'h0;
  localparam logic [TOUT_W-1:0]   TOUT_RST   = 16'h0000;

  // baud timing: sixteen ticks per bit, fraction in eighths
  localparam logic [3:0] OS_LAST    = 4'hF;
  localparam logic [3:0] FRAC_CARRY = 4'h8;
endpackage

// ==== design/ushbr_sync.sv ====
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module ushbr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// ==== design/ushbr_regs.sv ====
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// Behaviour
// [RL1] sticky break flag until status reset
// [RL2] live receive/transmit dma end-of-transfer bits
// [RL3] sticky overrun flag until status reset
// [RL4] sticky framing flag on low stop
// [RL5] sticky parity flag until status reset
// [RL6] time-out flag after start; clear if zero
// [RL7] tx idle needs both empty and enabled
// [RL8] sticky iteration flag until iteration reset
// [RL9] live dma buffer empty and full bits
// [RL10] sticky non-ack flag until non-ack reset
// [RL11] modem change flags, cleared by status read
// [RL12] status shows synchronized modem input levels
// [RL13] receive holding returns nine-bit character
// [RL14] receive bit 15 gives sync type
// [RL15] written character sent after current one
// [RL16] transmit bit 15 selects sync delimiter
// [RL17] baud register: divider and fraction fields
// [RL18] zero divider stops baud clock
// [RL19] fraction adds eighths to the divider
// [RL20] rx ready set on char, cleared by read
// [RL21] status reset clears four error flags
module ushbr_regs
  import ushbr_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [ushbr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [ushbr_pkg::DATA_W-1:0] pwdata_i,
  output logic      [ushbr_pkg::DATA_W-1:0] prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      rx_char_valid_i,
  input  wire logic [ushbr_pkg::CHAR_W-1:0] rx_char_i,
  input  wire logic                      rx_sync_type_i,
  input  wire logic                      rx_break_evt_i,
  input  wire logic                      rx_frame_err_i,
  input  wire logic                      rx_parity_err_i,
  input  wire logic                      nonack_evt_i,
  input  wire logic                      iter_limit_evt_i,
  input  wire logic                      rx_dma_done_i,
  input  wire logic                      tx_dma_done_i,
  input  wire logic                      tx_dma_buf_empty_i,
  input  wire logic                      rx_dma_buf_full_i,
  input  wire logic [ushbr_pkg::MODEM_W-1:0] modem_pins_i,
  output logic      [ushbr_pkg::CHAR_W-1:0] tx_char_o,
  output logic                           tx_sync_type_o,
  output logic                           tx_valid_o,
  input  wire logic                      tx_take_i,
  input  wire logic                      tx_shift_empty_i,
  output logic                           tx_enable_o,
  output logic                           os_tick_o,
  output logic                           bit_tick_o
);
  import ushbr_pkg::*;

  // bus phases; every access completes without wait states
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic hit_ctl;
  logic hit_sta;
  logic hit_rxh;
  logic hit_txh;
  logic hit_baud;
  logic hit_tout;
  logic mapped;
  assign setup    = psel_i & ~penable_i;
  assign wr_acc   = psel_i & penable_i & pwrite_i;
  assign rd_acc   = psel_i & penable_i & ~pwrite_i;
  assign hit_ctl  = (paddr_i == OFS_CONTROL);
  assign hit_sta  = (paddr_i == OFS_STATUS);
  assign hit_rxh  = (paddr_i == OFS_RX_HOLD);
  assign hit_txh  = (paddr_i == OFS_TX_HOLD);
  assign hit_baud = (paddr_i == OFS_BAUD);
  assign hit_tout = (paddr_i == OFS_RX_TOUT);
  assign mapped   = hit_ctl | hit_sta | hit_rxh | hit_txh | hit_baud | hit_tout;
  assign pready_o = 1'b1;

  // control commands are one-cycle strobes at the access edge
  logic cmd_sta_rst;
  logic cmd_it_rst;
  logic cmd_tout;
  logic cmd_nack_rst;
  logic cmd_tx_en;
  logic cmd_tx_dis;
  assign cmd_sta_rst  = wr_acc & hit_ctl & pwdata_i[CTL_STATUS_RST];
  assign cmd_it_rst   = wr_acc & hit_ctl & pwdata_i[CTL_ITER_RST];
  assign cmd_tout     = wr_acc & hit_ctl & pwdata_i[CTL_START_TOUT];
  assign cmd_nack_rst = wr_acc & hit_ctl & pwdata_i[CTL_NONACK_RST];
  assign cmd_tx_en    = wr_acc & hit_ctl & pwdata_i[CTL_TX_ENABLE];
  assign cmd_tx_dis   = wr_acc & hit_ctl & pwdata_i[CTL_TX_DISABLE];

  // modem pins arrive from outside and are synchronised first
  logic [MODEM_W-1:0] modem_lvl;
  ushbr_sync #(
    .W (MODEM_W)
  ) u_modem_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (modem_pins_i),
    .sync_o    (modem_lvl)
  );

  // state registers
  logic                 break_reg,   break_next;
  logic                 ovr_reg,     ovr_next;
  logic                 frame_reg,   frame_next;
  logic                 parity_reg,  parity_next;
  logic                 iter_reg,    iter_next;
  logic                 nack_reg,    nack_next;
  logic                 tflag_reg,   tflag_next;
  logic                 rx_ready_flag_reg,   rx_ready_flag_next;
  logic                 fresh_reg,   fresh_next;
  logic [CHAR_W-1:0]    rxchar_reg,  rxchar_next;
  logic                 rxsync_reg,  rxsync_next;
  logic [MODEM_W-1:0]   chg_reg,     chg_next;
  logic [MODEM_W-1:0]   prev_reg,    prev_next;
  logic [1:0]           settle_reg,  settle_next;
  logic                 txfull_reg,  txfull_next;
  logic [CHAR_W-1:0]    txchar_reg,  txchar_next;
  logic                 txsync_reg,  txsync_next;
  logic                 txen_reg,    txen_next;
  logic [CLKDIV_W-1:0]  clkdiv_reg,  clkdiv_next;
  logic [FRAC_W-1:0]    frac_reg,    frac_next;
  logic [TOUT_W-1:0]    tout_reg,    tout_next;
  logic [TOUT_W-1:0]    tcnt_reg,    tcnt_next;
  logic                 tarm_reg,    tarm_next;
  logic [CLKDIV_W-1:0]  dcnt_reg,    dcnt_next;
  logic [3:0]           facc_reg,    facc_next;
  logic                 extra_reg,   extra_next;
  logic [3:0]           ocnt_reg,    ocnt_next;
  logic                 ostick_reg,  ostick_next;
  logic                 btick_reg,   btick_next;
  logic [DATA_W-1:0]    prdata_reg,  prdata_next;
  logic                 perr_reg,    perr_next;

  // live status views
  logic                 tx_ready;
  logic                 tx_idle;
  logic                 rxh_clear;
  logic                 tx_taken;
  logic [DATA_W-1:0]    status_word;
  assign tx_taken  = txfull_reg & txen_reg & tx_take_i;
  assign tx_ready  = txen_reg & ~txfull_reg;
  assign tx_idle   = txen_reg & ~txfull_reg & tx_shift_empty_i; // RL7
  // a char that landed after the read snapshot must survive the read
  assign rxh_clear = rd_acc & hit_rxh & ~fresh_reg;

  // status word assembly
  always_comb begin
    status_word = '0;
    status_word[ST_RX_READY]     = rx_ready_flag_reg;
    status_word[ST_TX_READY]     = tx_ready;
    status_word[ST_BREAK]        = break_reg;
    status_word[ST_RX_DMA_DONE]  = rx_dma_done_i; // RL2
    status_word[ST_TX_DMA_DONE]  = tx_dma_done_i; // RL2
    status_word[ST_OVERRUN]      = ovr_reg;
    status_word[ST_FRAME]        = frame_reg;
    status_word[ST_PARITY]       = parity_reg;
    status_word[ST_TIMEOUT]      = tflag_reg;
    status_word[ST_TX_IDLE]      = tx_idle;
    status_word[ST_ITERATION]    = iter_reg;
    status_word[ST_TX_BUF_EMPTY] = tx_dma_buf_empty_i; // RL9
    status_word[ST_RX_BUF_FULL]  = rx_dma_buf_full_i; // RL9
    status_word[ST_NONACK]       = nack_reg;
    status_word[ST_CHANGE_LSB +: MODEM_W] = chg_reg;
    status_word[ST_LEVEL_LSB +: MODEM_W]  = modem_lvl; // RL12
  end

  // sticky event flags: a set in the clearing cycle wins
  always_comb begin
    break_next  = rx_break_evt_i | (break_reg & ~cmd_sta_rst); // RL1 RL21
    ovr_next    = (rx_char_valid_i & rx_ready_flag_reg & ~rxh_clear)
                  | (ovr_reg & ~cmd_sta_rst); // RL3 RL21
    frame_next  = rx_frame_err_i | (frame_reg & ~cmd_sta_rst); // RL4 RL21
    parity_next = rx_parity_err_i | (parity_reg & ~cmd_sta_rst); // RL5 RL21
    iter_next   = iter_limit_evt_i | (iter_reg & ~cmd_it_rst); // RL8
    nack_next   = nonack_evt_i | (nack_reg & ~cmd_nack_rst); // RL10
  end

  // receive holding and ready flag
  always_comb begin
    rx_ready_flag_next  = rx_char_valid_i | (rx_ready_flag_reg & ~rxh_clear); // RL20
    fresh_next  = rx_char_valid_i | (fresh_reg & ~(setup & hit_rxh));
    rxchar_next = rx_char_valid_i ? rx_char_i : rxchar_reg; // RL13
    rxsync_next = rx_char_valid_i ? rx_sync_type_i : rxsync_reg; // RL14
  end

  // modem change detection; only bits seen by the read are cleared
  always_comb begin
    settle_next = (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
    prev_next   = modem_lvl;
    chg_next    = chg_reg;
    if (rd_acc & hit_sta) begin
      chg_next = chg_reg & ~prdata_reg[ST_CHANGE_LSB +: MODEM_W]; // RL11
    end
    if (settle_reg == 2'h3) begin
      chg_next = chg_next | (modem_lvl ^ prev_reg); // RL11
    end
  end

  // transmit holding; a write while a character waits is dropped
  always_comb begin
    txen_next   = (txen_reg | cmd_tx_en) & ~cmd_tx_dis;
    txchar_next = txchar_reg;
    txsync_next = txsync_reg;
    txfull_next = txfull_reg & ~tx_taken; // RL15
    if (wr_acc & hit_txh & (~txfull_reg | tx_taken)) begin
      txchar_next = pwdata_i[CHAR_W-1:0]; // RL15
      txsync_next = pwdata_i[SYNC_BIT]; // RL16
      txfull_next = 1'b1;
    end
  end

  // configuration registers
  always_comb begin
    clkdiv_next = clkdiv_reg;
    frac_next   = frac_reg;
    tout_next   = tout_reg;
    if (wr_acc & hit_baud) begin
      clkdiv_next = pwdata_i[CLKDIV_LSB +: CLKDIV_W]; // RL17
      frac_next   = pwdata_i[FRAC_LSB +: FRAC_W]; // RL17
    end
    if (wr_acc & hit_tout) begin
      tout_next = pwdata_i[TOUT_W-1:0];
    end
  end

  // baud generator: period is divider plus fraction/8 clocks on average
  logic [CLKDIV_W:0] period_last;
  logic [3:0]        facc_sum;
  logic              period_end;
  assign period_last = {1'b0, clkdiv_reg} - 17'h00001 + {16'h0000, extra_reg};
  assign period_end  = ({1'b0, dcnt_reg} >= period_last);
  assign facc_sum    = facc_reg + {1'b0, frac_reg};
  always_comb begin
    dcnt_next   = dcnt_reg + 16'h0001;
    facc_next   = facc_reg;
    extra_next  = extra_reg;
    ocnt_next   = ocnt_reg;
    ostick_next = 1'b0;
    btick_next  = 1'b0;
    if (clkdiv_reg == CLKDIV_RST) begin
      dcnt_next  = '0; // RL18
      facc_next  = '0;
      extra_next = 1'b0;
      ocnt_next  = '0;
    end else if (period_end) begin
      dcnt_next   = '0;
      ostick_next = 1'b1; // RL18
      // a sum of eight or more stretches the next period by one clock
      if (facc_sum >= FRAC_CARRY) begin
        facc_next  = facc_sum - FRAC_CARRY; // RL19
        extra_next = 1'b1; // RL19
      end else begin
        facc_next  = facc_sum;
        extra_next = 1'b0;
      end
      ocnt_next  = ocnt_reg + 4'h1;
      btick_next = (ocnt_reg == OS_LAST);
    end
  end

  // receive time-out counted in bit periods after the start command
  always_comb begin
    tcnt_next  = tcnt_reg;
    tarm_next  = tarm_reg;
    tflag_next = tflag_reg;
    if (cmd_tout) begin
      tcnt_next  = tout_reg;
      tarm_next  = (tout_reg != TOUT_RST);
      tflag_next = 1'b0;
    end else if (tarm_reg & btick_reg) begin
      tcnt_next = tcnt_reg - 16'h0001;
      if (tcnt_reg == 16'h0001) begin
        tarm_next  = 1'b0;
        tflag_next = 1'b1; // RL6
      end
    end
    // a zero time-out value forces the flag clear
    if (tout_reg == TOUT_RST) begin
      tarm_next  = 1'b0;
      tflag_next = 1'b0; // RL6
    end
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_next = prdata_reg;
    perr_next   = perr_reg;
    if (setup) begin
      perr_next   = ~mapped;
      prdata_next = '0;
      if (!pwrite_i) begin
        if (hit_sta) begin
          prdata_next = status_word;
        end else if (hit_rxh) begin
          prdata_next[CHAR_W-1:0] = rxchar_reg; // RL13
          prdata_next[SYNC_BIT]   = rxsync_reg; // RL14
        end else if (hit_baud) begin
          prdata_next[CLKDIV_LSB +: CLKDIV_W] = clkdiv_reg;
          prdata_next[FRAC_LSB +: FRAC_W]     = frac_reg;
        end else if (hit_tout) begin
          prdata_next[TOUT_W-1:0] = tout_reg;
        end
      end
    end
  end

  // all state registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      break_reg  <= 1'b0;
      ovr_reg    <= 1'b0;
      frame_reg  <= 1'b0;
      parity_reg <= 1'b0;
      iter_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      tflag_reg  <= 1'b0;
      rx_ready_flag_reg  <= 1'b0;
      fresh_reg  <= 1'b0;
      rxchar_reg <= '0;
      rxsync_reg <= 1'b0;
      chg_reg    <= '0;
      prev_reg   <= '0;
      settle_reg <= 2'h0;
      txfull_reg <= 1'b0;
      txchar_reg <= '0;
      txsync_reg <= 1'b0;
      txen_reg   <= 1'b0;
      clkdiv_reg <= CLKDIV_RST;
      frac_reg   <= FRAC_RST;
      tout_reg   <= TOUT_RST;
      tcnt_reg   <= '0;
      tarm_reg   <= 1'b0;
      dcnt_reg   <= '0;
      facc_reg   <= '0;
      extra_reg  <= 1'b0;
      ocnt_reg   <= '0;
      ostick_reg <= 1'b0;
      btick_reg  <= 1'b0;
      prdata_reg <= '0;
      perr_reg   <= 1'b0;
    end else begin
      break_reg  <= break_next;
      ovr_reg    <= ovr_next;
      frame_reg  <= frame_next;
      parity_reg <= parity_next;
      iter_reg   <= iter_next;
      nack_reg   <= nack_next;
      tflag_reg  <= tflag_next;
      rx_ready_flag_reg  <= rx_ready_flag_next;
      fresh_reg  <= fresh_next;
      rxchar_reg <= rxchar_next;
      rxsync_reg <= rxsync_next;
      chg_reg    <= chg_next;
      prev_reg   <= prev_next;
      settle_reg <= settle_next;
      txfull_reg <= txfull_next;
      txchar_reg <= txchar_next;
      txsync_reg <= txsync_next;
      txen_reg   <= txen_next;
      clkdiv_reg <= clkdiv_next;
      frac_reg   <= frac_next;
      tout_reg   <= tout_next;
      tcnt_reg   <= tcnt_next;
      tarm_reg   <= tarm_next;
      dcnt_reg   <= dcnt_next;
      facc_reg   <= facc_next;
      extra_reg  <= extra_next;
      ocnt_reg   <= ocnt_next;
      ostick_reg <= ostick_next;
      btick_reg  <= btick_next;
      prdata_reg <= prdata_next;
      perr_reg   <= perr_next;
    end
  end

  // outputs
  assign prdata_o       = prdata_reg;
  assign pslverr_o      = perr_reg;
  assign tx_char_o      = txchar_reg;
  assign tx_sync_type_o = txsync_reg;
  assign tx_valid_o     = txfull_reg & txen_reg;
  assign tx_enable_o    = txen_reg;
  assign os_tick_o      = ostick_reg;
  assign bit_tick_o     = btick_reg;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_status_read;
    setup & hit_sta & ~pwrite_i ##1 rd_acc & hit_sta;
  endsequence
  sequence s_rxh_read;
    setup & hit_rxh & ~pwrite_i & ~rx_char_valid_i ##1 rd_acc & hit_rxh & ~rx_char_valid_i;
  endsequence

  property p_break_sticky;
    rx_break_evt_i ##1 !cmd_sta_rst [*2] |-> break_reg;
  endproperty
  a_break_sticky: assert property (p_break_sticky) else $error("break flag lost"); // RL1

  property p_dma_live;
    setup & hit_sta & ~pwrite_i |=> prdata_o[ST_RX_DMA_DONE] == $past(rx_dma_done_i)
      && prdata_o[ST_TX_BUF_EMPTY] == $past(tx_dma_buf_empty_i);
  endproperty
  a_dma_live: assert property (p_dma_live) else $error("dma status not live"); // RL2 RL9

  property p_overrun;
    rx_char_valid_i & rx_ready_flag_reg & ~(rd_acc & hit_rxh) |=> ovr_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RL3

  property p_err_clear;
    cmd_sta_rst & ~rx_frame_err_i & ~rx_parity_err_i & ~rx_break_evt_i & ~nonack_evt_i
      & ~cmd_nack_rst |=> !frame_reg && !parity_reg && !break_reg && $stable(nack_reg);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("status reset wrong"); // RL4 RL5 RL21

  property p_tout_zero;
    (tout_reg == TOUT_RST) [*2] |-> !tflag_reg;
  endproperty
  a_tout_zero: assert property (p_tout_zero) else $error("time-out set while zero"); // RL6

  property p_tx_idle;
    cmd_tx_dis |=> !status_word[ST_TX_IDLE] && !tx_valid_o;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx idle wrong"); // RL7

  property p_iter_nack;
    (iter_limit_evt_i |=> iter_reg) and (nonack_evt_i |=> nack_reg);
  endproperty
  a_iter_nack: assert property (p_iter_nack) else $error("iteration or nack lost"); // RL8 RL10

  property p_chg_clear;
    s_status_read ##0 (settle_reg == 2'h3) ##0 (modem_lvl == prev_reg)
      |=> (chg_reg & $past(prdata_reg[ST_CHANGE_LSB +: MODEM_W])) == '0;
  endproperty
  a_chg_clear: assert property (p_chg_clear) else $error("change flag not cleared"); // RL11

  property p_rxh_clear;
    s_rxh_read |=> !rx_ready_flag_reg;
  endproperty
  a_rxh_clear: assert property (p_rxh_clear) else $error("rx ready not cleared"); // RL20

  property p_baud_stop;
    (clkdiv_reg == CLKDIV_RST) [*2] |-> !os_tick_o;
  endproperty
  a_baud_stop: assert property (p_baud_stop) else $error("baud tick with zero divider"); // RL18

  property p_tx_write;
    wr_acc & hit_txh & ~txfull_reg & txen_reg |=> tx_valid_o
      && tx_char_o == $past(pwdata_i[CHAR_W-1:0]) && tx_sync_type_o == $past(pwdata_i[SYNC_BIT]);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx holding not loaded"); // RL15 RL16
endmodule

// ==== tb/ushbr_far_model.sv ====
`timescale 1ns/10ps
// far-side shifter: waits a random stall before taking, then stays busy shifting
module ushbr_far_model
  import ushbr_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic [ushbr_pkg::CHAR_W-1:0] tx_char_i,
  input  wire logic                       tx_sync_type_i,
  input  wire logic                       tx_valid_i,
  output logic                            tx_take_o,
  output logic                            tx_shift_empty_o,
  output logic                            got_o,
  output logic      [ushbr_pkg::CHAR_W:0]   got_char_o
);
  int stall;
  int busy;
  assign tx_shift_empty_o = (busy == 0);
  // a new char is only taken once the previous one has left the shifter
  always @(posedge clk_sys_i) begin
    got_o <= 1'b0;
    if (rst_i) begin
      tx_take_o <= 1'b0;
      stall     <= 0;
      busy      <= 0;
    end else if (tx_take_o && tx_valid_i) begin
      tx_take_o  <= 1'b0;
      got_o      <= 1'b1;
      got_char_o <= {tx_sync_type_i, tx_char_i};
      busy       <= 20;
      stall      <= $urandom_range(4, 0);
    end else if (busy > 0) begin
      busy <= busy - 1;
    end else if (tx_valid_i) begin
      if (stall == 0) tx_take_o <= 1'b1;
      else stall <= stall - 1;
    end
  end
endmodule

// ==== tb/ushbr_regs_bench.sv ====
`timescale 1ns/10ps
module ushbr_regs_bench;
  import ushbr_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [ADDR_W-1:0] paddr_i   = '0;
  logic [DATA_W-1:0] pwdata_i  = '0;
  logic [DATA_W-1:0] prdata_o;
  logic              pready_o, pslverr_o, tx_sync_type_o, tx_valid_o, tx_enable_o;
  logic              os_tick_o, bit_tick_o, take, sh_empty, got;
  logic              rx_v      = 1'b0;
  logic              rx_s      = 1'b0;
  logic [CHAR_W-1:0] rx_c      = '0;
  logic [4:0]        ev        = '0;  // break, frame, parity, non-ack, iteration
  logic [3:0]        dma       = '0;  // rx done, tx done, tx empty, rx full
  logic [3:0]        modem     = '0;
  logic [3:0]        chg;
  logic [CHAR_W-1:0] tx_char_o;
  logic [CHAR_W:0]   got_char;
  logic [64:0]       rq[$];  // read notes: mask, slave error, data
  logic [CHAR_W:0]   tq[$];  // tx notes: sync, char
  logic [64:0]       note;
  logic [31:0]       v;
  int                err_total = 0;
  int                samples_checked = 0;
  int                n;

  always #25 clk_sys_i = ~clk_sys_i;

  ushbr_regs dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_char_valid_i(rx_v), .rx_char_i(rx_c),
    .rx_sync_type_i(rx_s), .rx_break_evt_i(ev[0]), .rx_frame_err_i(ev[1]),
    .rx_parity_err_i(ev[2]), .nonack_evt_i(ev[3]), .iter_limit_evt_i(ev[4]),
    .rx_dma_done_i(dma[0]), .tx_dma_done_i(dma[1]), .tx_dma_buf_empty_i(dma[2]),
    .rx_dma_buf_full_i(dma[3]), .modem_pins_i(modem), .tx_char_o(tx_char_o),
    .tx_sync_type_o(tx_sync_type_o), .tx_valid_o(tx_valid_o), .tx_take_i(take),
    .tx_shift_empty_i(sh_empty), .tx_enable_o(tx_enable_o), .os_tick_o(os_tick_o),
    .bit_tick_o(bit_tick_o));

  ushbr_far_model far_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_char_i(tx_char_o),
    .tx_sync_type_i(tx_sync_type_o), .tx_valid_i(tx_valid_o), .tx_take_o(take),
    .tx_shift_empty_o(sh_empty), .got_o(got), .got_char_o(got_char));

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [32:0] a, input logic [32:0] b, input string m);
    samples_checked++;
    if (a !== b) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, a, b);
    end
  endtask

  // answer watcher: each finished read or taken char retires the oldest note
  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && rq.size() > 0) begin
      note = rq.pop_front();
      chk({pslverr_o, prdata_o & note[64:33]}, note[32:0], "read");
    end
    if (got === 1'b1) chk({23'h0, got_char}, {23'h0, tq.pop_front()}, "tx char");
  end

  // one transfer; an idle edge follows so a next call never re-drives psel in this step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      end_of_test();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic er);
    rq.push_back({m, er, e & m});
    apb(1'b0, a, 32'h0);
  endtask

  // span of eight tick intervals; the first interval after a rewrite is skipped
  task automatic tick_span(input int exp);
    int t;
    int c;
    t = 0;
    c = 0;
    for (int i = 0; i < 1000 && t < 10; i++) begin
      @(negedge clk_sys_i);
      if (os_tick_o === 1'b1) t++;
      if (t >= 2) c++;
    end
    @(posedge clk_sys_i);
    chk(33'(c - 1), 33'(exp), "tick span");
  endtask

  initial begin
    v = $urandom(4620);
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_STATUS, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0, 1'b1);
    v = $urandom;
    apb(1'b1, OFS_BAUD, v);
    rd(OFS_BAUD, 32'h0007FFFF, v, 1'b0);
    for (int i = 0; i < 3; i++) begin
      v = 1 + $urandom % 4;
      v[18:16] = 3'($urandom % 8);
      apb(1'b1, OFS_BAUD, v);
      tick_span(8 * v[15:0] + v[18:16]);
    end
    apb(1'b1, OFS_BAUD, 32'h0);
    n = 0;
    repeat (64) @(negedge clk_sys_i) if (os_tick_o !== 1'b0) n++;
    @(posedge clk_sys_i);
    chk(33'(n), 33'h0, "ticks with divider zero");
    // two chars back to back plus every error event in the first cycle
    v = $urandom;
    rx_v  <= 1'b1;
    rx_c  <= v[8:0];
    rx_s  <= v[9];
    ev    <= 5'h1F;
    @(posedge clk_sys_i);
    rx_c  <= v[24:16];
    rx_s  <= v[25];
    ev    <= 5'h00;
    @(posedge clk_sys_i);
    rx_v  <= 1'b0;
    rd(OFS_STATUS, 32'h000025E5, 32'h000024E5, 1'b0);
    rd(OFS_RX_HOLD, 32'h000081FF, {16'h0, v[25], 6'h0, v[24:16]}, 1'b0);
    apb(1'b1, OFS_CONTROL, 32'h1 << CTL_STATUS_RST);
    rd(OFS_STATUS, 32'h000025E5, 32'h00002400, 1'b0);
    apb(1'b1, OFS_CONTROL, (32'h1 << CTL_ITER_RST) | (32'h1 << CTL_NONACK_RST));
    rd(OFS_STATUS, 32'h000025E5, 32'h0, 1'b0);
    // live dma levels and modem pins; change flags expected from the xor with old levels
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      chg = modem ^ v[7:4];
      dma   <= v[3:0];
      modem <= v[7:4];
      repeat (4) @(posedge clk_sys_i);
      rd(OFS_STATUS, 32'h00FF1818, {8'h0, v[7:4], chg, 3'h0, v[3:2], 6'h0, v[1:0], 3'h0},
         1'b0);
      rd(OFS_STATUS, 32'h000F0000, 32'h0, 1'b0);
    end
    apb(1'b1, OFS_CONTROL, 32'h1 << CTL_TX_ENABLE);
    rd(OFS_STATUS, 32'h00000202, 32'h00000202, 1'b0);
    chk(33'(tx_enable_o), 33'h1, "tx enable");
    // each next char is written while the previous one is still shifting
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      tq.push_back({v[15], v[8:0]});
      apb(1'b1, OFS_TX_HOLD, v);
      for (n = 0; n < 200 && tq.size() > 0; n++) @(posedge clk_sys_i);
      if (tq.size() > 0) begin
        err_total++;
        end_of_test();
      end
    end
    rd(OFS_STATUS, 32'h00000202, 32'h00000002, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    rd(OFS_STATUS, 32'h00000202, 32'h00000202, 1'b0);
    apb(1'b1, OFS_CONTROL, 32'h1 << CTL_TX_DISABLE);
    rd(OFS_STATUS, 32'h00000202, 32'h0, 1'b0);
    // divider one gives a bit tick every sixteen clocks, so two ticks need over 16
    apb(1'b1, OFS_BAUD, 32'h1);
    apb(1'b1, OFS_RX_TOUT, 32'h2);
    apb(1'b1, OFS_CONTROL, 32'h1 << CTL_START_TOUT);
    rd(OFS_STATUS, 32'h00000100, 32'h0, 1'b0);
    repeat (40) @(posedge clk_sys_i);
    rd(OFS_STATUS, 32'h00000100, 32'h00000100, 1'b0);
    apb(1'b1, OFS_RX_TOUT, 32'h0);
    rd(OFS_STATUS, 32'h00000100, 32'h0, 1'b0);
    end_of_test();
  end
endmodule
